//--- rtl/phy_strap_led_pin_logic.sv
// Strap capture and pin sharing for the LED, carrier, receive data, collision and interrupt pins.
// Assumes the core supplies link status on CLK and the board pins are asynchronous to CLK.
`timescale 1ns/1ps

module phy_strap_led_pin_logic
   import strap_pkg::*;
(
   // Clock, reset and enable.
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // External reset pin, active low.
   input wire logic EXT_RESET_N,
   // Status from the transceiver core.
   input wire logic SPEED_100,
   input wire logic LINK_UP,
   input wire logic CARRIER_SENSE,
   input wire logic FULL_DUPLEX,
   input wire logic [RXD_W-1:0] RX_DATA,
   input wire logic COLLISION,
   input wire logic CRS_DV,
   input wire logic IRQ_REQ,
   // LED pins: speed, link, activity, duplex.
   input wire logic [LED_W-1:0] LED_IN,
   output logic [LED_W-1:0] LED_OUT,
   output logic [LED_W-1:0] LED_OE,
   // Carrier sense pin.
   input wire logic CRS_IN,
   output logic CRS_OUT,
   output logic CRS_OE,
   // Receive data pins.
   input wire logic [RXD_W-1:0] RXD_IN,
   output logic [RXD_W-1:0] RXD_OUT,
   output logic [RXD_W-1:0] RXD_OE,
   // Collision or carrier-sense-data-valid pin.
   input wire logic COL_IN,
   output logic COL_OUT,
   output logic COL_OE,
   // Interrupt or transmit error pin.
   input wire logic IRQ_PIN_IN,
   output logic IRQ_PIN_OUT,
   output logic IRQ_PIN_OE,
   // Latched configuration and pin-derived inputs.
   output logic [ADDR_W-1:0] PHY_ADDR,
   output logic [MODE_W-1:0] OP_MODE,
   output logic RMII_SEL,
   output logic IRQ_MODE,
   output logic STRAPS_VALID,
   output logic MODE_LOAD,
   output logic TX_ERR
);

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync1;
   logic [PIN_W-1:0] sync2;
   logic [PIN_W-1:0] sync3;
   logic [PIN_W-1:0] filt;
   phase_t phase;
   logic release_evt;

   // Every board pin is gathered into one vector so one filter serves all.
   assign pin_raw = {EXT_RESET_N, IRQ_PIN_IN, COL_IN, RXD_IN, CRS_IN, LED_IN};

   // Three-stage synchroniser per pin; a level counts only once stages two and three agree.
   // This rejects a one-sample glitch on any pin, the reset pin included.
   genvar g;
   generate
      for (g = 0; g < PIN_W; g++)
      begin : g_sync
         always_ff @(posedge CLK or posedge RST)
         begin
            if (RST)
            begin
               sync1[g] <= PIN_RST[g];
               sync2[g] <= PIN_RST[g];
               sync3[g] <= PIN_RST[g];
               filt[g] <= PIN_RST[g];
            end
            else if (CE)
            begin
               sync1[g] <= pin_raw[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
               if (sync2[g] == sync3[g])
               begin
                  filt[g] <= sync3[g];
               end
            end
         end
      end
   endgenerate

   // The release is the first cycle the filtered reset reads high while still in the strap phase.
   // A strap that moves within the filter delay of the reset rise may be taken at either level.
   assign release_evt = (phase == ST_STRAP) && filt[IDX_RST];

   // Phase tracking: low external reset returns the pins to the strap phase.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         phase <= ST_STRAP;
      end
      else if (CE)
      begin
         unique case (phase)
            ST_STRAP:
            begin
               if (filt[IDX_RST])
               begin
                  phase <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               if (!filt[IDX_RST])
               begin
                  phase <= ST_STRAP;
               end
            end
         endcase
      end
   end

   // Strap capture at the reset release; values hold until the next release.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         PHY_ADDR <= ADDR_RST;
         OP_MODE <= MODE_RST;
         RMII_SEL <= 1'b0;
         IRQ_MODE <= 1'b1;
         STRAPS_VALID <= 1'b0;
         MODE_LOAD <= 1'b0;
      end
      else if (CE)
      begin
         MODE_LOAD <= release_evt;
         if (release_evt)
         begin
            PHY_ADDR <= {filt[IDX_CRS], filt[IDX_LED0 +: LED_W]};
            OP_MODE <= filt[IDX_RXD0 +: MODE_W];
            // The pin has an internal pull-down, so a floating pin reads low.
            RMII_SEL <= filt[IDX_COL];
            // The pin has an internal pull-up, so a floating pin reads high.
            IRQ_MODE <= filt[IDX_RXD0 + RXD3_BIT];
            STRAPS_VALID <= 1'b1;
         end
         else if (phase == ST_RUN && !filt[IDX_RST])
         begin
            STRAPS_VALID <= 1'b0;
         end
      end
   end

   // Output enables: nothing drives a shared pin until its strap has been taken.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         LED_OE <= '0;
         CRS_OE <= 1'b0;
         RXD_OE <= '0;
         COL_OE <= 1'b0;
         IRQ_PIN_OE <= 1'b0;
      end
      else if (CE)
      begin
         if (phase == ST_RUN && filt[IDX_RST])
         begin
            LED_OE <= '1;
            CRS_OE <= 1'b1;
            RXD_OE <= '1;
            COL_OE <= 1'b1;
            // In transmit error mode the pin is an input and stays undriven.
            IRQ_PIN_OE <= IRQ_MODE;
         end
         else
         begin
            LED_OE <= '0;
            CRS_OE <= 1'b0;
            RXD_OE <= '0;
            COL_OE <= 1'b0;
            IRQ_PIN_OE <= 1'b0;
         end
      end
   end

   // Functional pin values; registered so every pin changes on a clock edge.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         LED_OUT <= {LED_W{~LED_ACTIVE}};
         CRS_OUT <= 1'b0;
         RXD_OUT <= '0;
         COL_OUT <= 1'b0;
         IRQ_PIN_OUT <= 1'b1;
      end
      else if (CE)
      begin
         LED_OUT[0] <= SPEED_100 ? LED_ACTIVE : ~LED_ACTIVE;
         LED_OUT[1] <= LINK_UP ? LED_ACTIVE : ~LED_ACTIVE;
         LED_OUT[2] <= CARRIER_SENSE ? LED_ACTIVE : ~LED_ACTIVE;
         LED_OUT[3] <= FULL_DUPLEX ? LED_ACTIVE : ~LED_ACTIVE;
         CRS_OUT <= CARRIER_SENSE;
         RXD_OUT <= RX_DATA;
         // RMII folds carrier and data valid onto the collision pin.
         COL_OUT <= RMII_SEL ? CRS_DV : COLLISION;
         IRQ_PIN_OUT <= ~IRQ_REQ;
      end
   end

   // Transmit error taken from the shared pin only when it is configured as an input.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         TX_ERR <= 1'b0;
      end
      else if (CE)
      begin
         TX_ERR <= STRAPS_VALID && !IRQ_MODE && filt[IDX_IRQ];
      end
   end

   // Checks on the pin logic.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_release;
      CE && release_evt;
   endsequence

   sequence s_loaded;
      MODE_LOAD && STRAPS_VALID;
   endsequence

   sequence s_run_kept;
      CE && filt[IDX_RST];
   endsequence

   AST_SPEED_LED: assert property (CE |=> LED_OUT[0] == ($past(SPEED_100) ? LED_ACTIVE : ~LED_ACTIVE))
      else $error("Speed LED does not follow selected speed.");
   AST_LINK_LED: assert property (CE |=> LED_OUT[1] == ($past(LINK_UP) ? LED_ACTIVE : ~LED_ACTIVE))
      else $error("Link LED does not follow link state.");
   AST_ACT_LED: assert property (CE |=> LED_OUT[2] == ($past(CARRIER_SENSE) ? LED_ACTIVE : ~LED_ACTIVE))
      else $error("Activity LED does not follow carrier sense.");
   AST_DUP_LED: assert property (CE |=> LED_OUT[3] == ($past(FULL_DUPLEX) ? LED_ACTIVE : ~LED_ACTIVE))
      else $error("Duplex LED does not follow duplex mode.");
   AST_ADDR_STRAP: assert property (s_release |=> PHY_ADDR == {$past(filt[IDX_CRS]), $past(filt[3:0])})
      else $error("Address not taken from strap pins.");
   AST_MODE_STRAP: assert property (s_release |=> s_loaded ##0 OP_MODE == $past(filt[7:5]))
      else $error("Mode not taken from receive data straps.");
   AST_RMII_STRAP: assert property (s_release |=> RMII_SEL == $past(filt[IDX_COL]))
      else $error("Interface selection not taken from collision strap.");
   AST_IRQ_STRAP: assert property (s_release |=> IRQ_MODE == $past(filt[8]))
      else $error("Interrupt pin mode not taken from strap.");
   AST_MODE_HOLD: assert property (!(CE && release_evt) |=> $stable(OP_MODE) && $stable(PHY_ADDR)
      && $stable(RMII_SEL) && $stable(IRQ_MODE))
      else $error("Mode bits changed outside a capture.");
   AST_PINS_FREE: assert property (phase == ST_STRAP |=> LED_OE == '0 && !CRS_OE && RXD_OE == '0
      && !COL_OE && !IRQ_PIN_OE)
      else $error("Shared pin driven during strap phase.");
   AST_TXERR_PIN: assert property (IRQ_MODE |-> !TX_ERR ##1 !IRQ_MODE || !TX_ERR)
      else $error("Transmit error seen while pin is an interrupt.");

   // Pin roles once running, and the pins that simply follow the core.
   AST_OE_RUN: assert property (s_release ##1 s_run_kept |=> LED_OE == '1 && CRS_OE && RXD_OE == '1)
      else $error("Shared pins not handed to their roles after capture.");
   AST_IRQ_OE: assert property (s_release ##1 s_run_kept |=> COL_OE && IRQ_PIN_OE == IRQ_MODE)
      else $error("Collision or interrupt pin role wrong after capture.");
   AST_CRS_PIN: assert property (CE |=> CRS_OUT == $past(CARRIER_SENSE))
      else $error("Carrier pin does not follow carrier sense.");
   AST_COL_PIN: assert property (CE |=> COL_OUT == ($past(RMII_SEL) ? $past(CRS_DV) : $past(COLLISION)))
      else $error("Collision pin shows the wrong source.");
   AST_IRQ_PIN: assert property (CE |=> IRQ_PIN_OUT == !$past(IRQ_REQ))
      else $error("Interrupt pin is not the inverted request.");
   AST_VALID_DROP: assert property (CE && phase == ST_RUN && !filt[IDX_RST] |=> !STRAPS_VALID)
      else $error("Straps still valid after the reset pin fell.");
   AST_LOAD_PULSE: assert property (CE && MODE_LOAD |=> !MODE_LOAD)
      else $error("Mode load pulse longer than one cycle.");

   // A low enable must freeze every register, the pin filter included.
   AST_CE_FREEZE: assert property (!CE |=> $stable(LED_OUT) && $stable(LED_OE) && $stable(PHY_ADDR)
      && $stable(OP_MODE) && $stable(STRAPS_VALID) && $stable(TX_ERR) && $stable(filt))
      else $error("State moved while the clock enable was low.");

endmodule // phy_strap_led_pin_logic

//--- rtl/strap_pkg.sv
// Constants shared by the strap capture and LED pin logic of the transceiver.
// Assumes a single 40 MHz clock domain; board pins reach the logic unsynchronised.
package strap_pkg;

   // Bit positions inside the vector of sampled pin inputs.
   localparam int IDX_LED0 = 0;
   localparam int IDX_CRS = 4;
   localparam int IDX_RXD0 = 5;
   localparam int IDX_COL = 9;
   localparam int IDX_IRQ = 10;
   localparam int IDX_RST = 11;
   localparam int PIN_W = 12;

   // Field widths.
   localparam int LED_W = 4;
   localparam int ADDR_W = 5;
   localparam int MODE_W = 3;
   localparam int RXD_W = 4;
   localparam int RXD3_BIT = 3;

   // Reset values of the latched configuration.
   localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
   localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
   localparam logic [PIN_W-1:0] PIN_RST = 12'h000;

   // Level that lights an LED pin.
   localparam logic LED_ACTIVE = 1'b1;

   // Pin phase: straps being sampled, or pins in their functional roles.
   typedef enum logic {ST_STRAP, ST_RUN} phase_t;

endpackage

//--- testbench/board_pins.sv
// Board model: strap resistors, LEDs and MAC on the shared pins.
// Assumes the design's enables are high while it drives a pin.
`timescale 1ns/1ps

module board_pins
   import strap_pkg::*;
(
   // Design pin drive.
   input wire logic [LED_W-1:0] led_out,
   input wire logic [LED_W-1:0] led_oe,
   input wire logic crs_out,
   input wire logic crs_oe,
   input wire logic [RXD_W-1:0] rxd_out,
   input wire logic [RXD_W-1:0] rxd_oe,
   input wire logic col_out,
   input wire logic col_oe,
   input wire logic irq_out,
   input wire logic irq_oe,
   // Strap choices and MAC transmit error drive.
   input wire logic [ADDR_W-1:0] strap_addr,
   input wire logic [MODE_W-1:0] strap_mode,
   input wire logic col_pulled_up,
   input wire logic irq_sel_pulled_low,
   input wire logic mac_tx_err,
   // Resolved pin levels.
   output logic [LED_W-1:0] led_in,
   output logic crs_in,
   output logic [RXD_W-1:0] rxd_in,
   output logic col_in,
   output logic irq_in
);
   // An undriven pin shows its strap resistor, or the floating default.
   assign led_in = led_oe & led_out | ~led_oe & strap_addr[3:0];
   assign crs_in = crs_oe ? crs_out : strap_addr[4];
   assign rxd_in = rxd_oe & rxd_out | ~rxd_oe & {~irq_sel_pulled_low, strap_mode};
   assign col_in = col_oe ? col_out : col_pulled_up;
   // The MAC only drives the shared pin when the design leaves it free.
   assign irq_in = irq_oe ? irq_out : mac_tx_err;
endmodule // board_pins

//--- testbench/testbench.sv
// Self-checking bench for strap capture and LED pin sharing.
// Assumes the board model resolves every shared pin.
`timescale 1ns/1ps

module testbench;
   import strap_pkg::*;
   logic clk = 0, rst = 1, ce = 1, ext_n = 0, spd = 0, link = 0, crs = 0, fdx = 0;
   logic col = 0, crsdv = 0, irq = 0, txe = 0, s_col = 0, s_low = 0;
   logic [RXD_W-1:0] rxd = 4'h0, rxd_in, rxd_out, rxd_oe;
   logic [ADDR_W-1:0] s_addr = 5'h00, addr;
   logic [MODE_W-1:0] s_mode = 3'h0, mode;
   logic [LED_W-1:0] led_in, led_out, led_oe;
   logic crs_in, crs_out, crs_oe, col_in, col_out, col_oe, irq_in, irq_out, irq_oe;
   logic rmii, irqm, sv, ml, txerr;
   int n_errors = 0, compares = 0;

   phy_strap_led_pin_logic phy_strap_led_pin_logic_inst (.CLK(clk), .RST(rst), .CE(ce),
      .EXT_RESET_N(ext_n), .SPEED_100(spd), .LINK_UP(link), .CARRIER_SENSE(crs), .FULL_DUPLEX(fdx),
      .RX_DATA(rxd), .COLLISION(col), .CRS_DV(crsdv), .IRQ_REQ(irq), .LED_IN(led_in), .LED_OUT(led_out),
      .LED_OE(led_oe), .CRS_IN(crs_in), .CRS_OUT(crs_out), .CRS_OE(crs_oe), .RXD_IN(rxd_in),
      .RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .COL_IN(col_in), .COL_OUT(col_out), .COL_OE(col_oe),
      .IRQ_PIN_IN(irq_in), .IRQ_PIN_OUT(irq_out), .IRQ_PIN_OE(irq_oe), .PHY_ADDR(addr), .OP_MODE(mode),
      .RMII_SEL(rmii), .IRQ_MODE(irqm), .STRAPS_VALID(sv), .MODE_LOAD(ml), .TX_ERR(txerr));

   board_pins board_pins_inst (.led_out(led_out), .led_oe(led_oe), .crs_out(crs_out), .crs_oe(crs_oe),
      .rxd_out(rxd_out), .rxd_oe(rxd_oe), .col_out(col_out), .col_oe(col_oe), .irq_out(irq_out),
      .irq_oe(irq_oe), .strap_addr(s_addr), .strap_mode(s_mode), .col_pulled_up(s_col),
      .irq_sel_pulled_low(s_low), .mac_tx_err(txe), .led_in(led_in), .crs_in(crs_in), .rxd_in(rxd_in),
      .col_in(col_in), .irq_in(irq_in));

   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic ok, input string msg);
      compares++;
      if (!ok)
      begin
         n_errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic final_report;
      $display("Counts: %0d compares, %0d errors", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Pulses the board reset with fresh straps, then moves the straps to show they are ignored.
   task automatic capture(input logic [ADDR_W-1:0] a, input logic [MODE_W-1:0] m, input logic rm, input logic lo);
      int n;
      @(negedge clk);
      ext_n = 0;
      s_addr = a;
      s_mode = m;
      s_col = rm;
      s_low = lo;
      repeat (8) @(negedge clk);
      check(led_oe === 4'h0 && rxd_oe === 4'h0 && irq_oe === 1'b0 && sv === 1'b0, "pins driven in reset");
      ext_n = 1;
      for (n = 0; n < 12 && ml !== 1'b1; n++) @(posedge clk) #1;
      check(ml === 1'b1 && sv === 1'b1, "no capture pulse");
      check(addr === a, "address");
      check(mode === m, "mode");
      check(rmii === rm, "interface select");
      check(irqm === ~lo, "interrupt pin select");
      @(negedge clk);
      s_addr = ~a;
      s_mode = ~m;
      @(posedge clk) #1;
      check(ml === 1'b0 && led_oe === 4'hf && crs_oe === 1'b1 && rxd_oe === 4'hf, "roles");
      check(col_oe === 1'b1 && irq_oe === ~lo && addr === a && mode === m, "after capture");
      $display("test capture done");
   endtask

   // Walks status patterns through the LED, carrier, receive data, collision and interrupt pins.
   task automatic functional(input logic rm, input logic lo);
      logic [3:0] pats [5] = '{4'h0, 4'hf, 4'h5, 4'ha, 4'h3};
      foreach (pats[i])
      begin
         @(negedge clk);
         {fdx, crs, link, spd} = pats[i];
         {col, crsdv, irq} = pats[i][2:0];
         rxd = pats[i];
         @(posedge clk) #1;
         check(led_out === pats[i], "led pattern");
         check(crs_out === pats[i][2] && rxd_out === pats[i], "carrier or data");
         check(col_out === (rm ? pats[i][1] : pats[i][2]), "collision pin");
         check(irq_oe === ~lo && (lo || irq_out === ~pats[i][0]), "interrupt pin");
      end
      @(negedge clk);
      txe = 1;
      repeat (6) @(negedge clk);
      check(txerr === lo, "transmit error input");
      txe = 0;
      $display("test functional done");
   endtask

   // Holds the clock enable low while the core status moves, then lets it go.
   task automatic freeze;
      logic [LED_W-1:0] held;
      @(negedge clk);
      held = led_out;
      ce = 0;
      {fdx, crs, link, spd} = ~held;
      repeat (3) @(posedge clk) #1;
      check(led_out === held && ml === 1'b0 && sv === 1'b1, "state moved while disabled");
      @(negedge clk);
      ce = 1;
      @(posedge clk) #1;
      check(led_out === ~held, "led not updated after enable");
      $display("test freeze done");
   endtask

   // Clock at 40 MHz; the bench stands in for the board's reference clock.
   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // A hang is cut short well past the expected run of about 70 cycles.
   initial
   begin
      #(25 * 3000);
      n_errors++;
      final_report;
   end

   initial
   begin
      repeat (16) @(negedge clk);
      rst = 0;
      capture(5'h15, 3'h5, 1'b1, 1'b0);
      functional(1'b1, 1'b0);
      freeze;
      capture(5'h0a, 3'h2, 1'b0, 1'b1);
      functional(1'b0, 1'b1);
      final_report;
   end
endmodule // testbench
